// ==== logic/pvcr_pkg.sv ====
// pvcr_pkg: constants for the vendor control register bank.
// assumes a 50 MHz management-side clock and a 16-bit register map.
package pvcr_pkg;

  // register addresses (5-bit management address space)
  localparam logic [4:0] PVCR_ADDR_DIGITAL_POWER_CONTROL = 5'h10;
  localparam logic [4:0] PVCR_ADDR_ANALOG_FRONTEND_CONTROL = 5'h11;
  localparam logic [4:0] PVCR_ADDR_SYMBOL_ERROR_FRAME_COUNT = 5'h15;
  localparam logic [4:0] PVCR_ADDR_STRAP_OVERRIDE_CONTROL = 5'h16;

  // field positions
  localparam int PVCR_BIT_PLL_OFF = 4;
  localparam int PVCR_BIT_SLOW_OSC = 5;
  localparam int PVCR_BIT_WAKE_ENABLE = 15;
  localparam int PVCR_BIT_BCAST_DISABLE = 9;
  localparam int PVCR_BIT_REPEATER = 7;
  localparam int PVCR_BIT_MII_OVERRIDE = 0;

  // reset values; wake enable bit comes from its strap instead
  localparam logic [15:0] PVCR_RST_DIGITAL_POWER_CONTROL = 16'h0000;
  localparam logic [15:0] PVCR_RST_ANALOG_FRONTEND_CONTROL = 16'h0000;
  localparam logic [15:0] PVCR_RST_STRAP_OVERRIDE_CONTROL = 16'h0001;
  // implemented bits of the override register: 15, 14:11, 9, 8, 7, 0
  localparam logic [15:0] PVCR_MASK_STRAP_OVERRIDE = 16'hfb81;

  // management frame layout
  localparam logic [1:0] PVCR_OP_READ = 2'h2;
  localparam logic [1:0] PVCR_OP_WRITE = 2'h1;
  localparam logic [4:0] PVCR_HEADER_BITS = 5'h0c;
  localparam logic [4:0] PVCR_DATA_BITS = 5'h10;
  localparam logic [5:0] PVCR_PREAMBLE_MIN = 6'h20;
  localparam logic [4:0] PVCR_BROADCAST_ADDR = 5'h00;

  typedef enum logic [2:0] {
    PVCR_HUNT,
    PVCR_START,
    PVCR_HEADER,
    PVCR_TURN1,
    PVCR_TURN2,
    PVCR_RDATA,
    PVCR_WDATA
  } pvcr_state_t;

endpackage

// ==== logic/pvcr_error_counter.sv ====
// pvcr_error_counter: 16-bit counter of received symbol-error frames.
// assumes eventIn and clearIn are one-cycle pulses on clk.
`timescale 1ns/10ps
module pvcr_error_counter #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic eventIn,
  input wire logic clearIn,
  output logic [WIDTH-1:0] count
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } pvcr_cnt_state_t;

  pvcr_cnt_state_t state_reg;
  pvcr_cnt_state_t state_next;

  always_comb begin
    state_next = state_reg;
    // clear first, then add the event, so a same-cycle frame survives [R12]
    if (clearIn) begin
      state_next.count = '0; // [R4]
    end
    // saturate rather than wrap so software never sees a false small count
    if (eventIn && (state_next.count != {WIDTH{1'b1}})) begin
      state_next.count = state_next.count + 1'b1; // [R4] [R12]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign count = state_reg.count;

endmodule // pvcr_error_counter

// ==== logic/pvcr_registers.sv ====
// pvcr_registers: vendor control registers behind the serial management port.
// assumes mdc and mdioIn are synchronous to clk; mdc well below clk/4.
`timescale 1ns/10ps
// Function
// R1 - pll off bit stops pll in power-down
// R2 - slow oscillator bit deselects crystal input clock
// R3 - slow oscillator also powers down analog frontend
// R4 - symbol error frame count, cleared by read
// R5 - wake enable plus select field drive pins
// R6 - wake enable bit loaded from strap
// R7 - broadcast disable stops address zero broadcast
// R8 - repeater override forces back-to-back mode
// R9 - controller must also set mii override
// R10 - power-down mode enabled by expanded control bit
// R11 - mii override forces mii, resets to one
// R12 - read returns old count, no event lost
module pvcr_registers
  import pvcr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  input wire logic [4:0] phyAddress,
  input wire logic wakeOutputEnableStrap,
  input wire logic repeaterStrap,
  input wire logic miiStrap,
  input wire logic edpdEnable,
  input wire logic edpdActive,
  input wire logic softPowerDown,
  input wire logic [1:0] wakeOutputSelect,
  input wire logic wakeEvent,
  input wire logic symbolErrorFrame,
  output logic pllShutdown,
  output logic slowOscSelect,
  output logic analogPowerDown,
  output logic wakePinA,
  output logic wakePinB,
  output logic repeaterPairingMode,
  output logic miiMode
);

  typedef struct packed {
    pvcr_state_t st;
    logic [4:0] bitCnt;
    logic [5:0] ones;
    logic [15:0] shift;
    logic [4:0] regAddr;
    logic strapDone;
    logic mdcPrev;
    logic [15:0] digitalPowerControl;
    logic [15:0] analogFrontendControl;
    logic [15:0] strapOverrideControl;
    logic mdioOut;
    logic mdioOe;
    logic pllShutdown;
    logic slowOscSelect;
    logic analogPowerDown;
    logic wakePinA;
    logic wakePinB;
    logic repeaterPairingMode;
    logic miiMode;
  } pvcr_regs_state_t;

  pvcr_regs_state_t state_reg;
  pvcr_regs_state_t state_next;
  logic [15:0] errorCount;
  logic mdcRise;
  logic countClear;
  logic addrMatch;
  logic [15:0] readValue;
  logic wakeEnable;
  logic wakeLevel;

  pvcr_error_counter #(
    .WIDTH(16)
  ) u_error_counter (
    .clk(clk),
    .reset_n(reset_n),
    .eventIn(symbolErrorFrame),
    .clearIn(countClear),
    .count(errorCount)
  );

  assign mdcRise = mdc && !state_reg.mdcPrev;

  // clear on the snapshot edge itself, so a frame counted there is kept [R12]
  assign countClear = mdcRise && (state_reg.st == PVCR_TURN2) && state_reg.mdioOe &&
    (state_reg.regAddr == PVCR_ADDR_SYMBOL_ERROR_FRAME_COUNT); // [R4]

  // own address always; address zero too unless broadcast is disabled
  assign addrMatch = (state_reg.shift[9:5] == phyAddress) ||
    ((state_reg.shift[9:5] == PVCR_BROADCAST_ADDR) &&
     !state_reg.strapOverrideControl[PVCR_BIT_BCAST_DISABLE]); // [R7]

  always_comb begin
    unique case (state_reg.shift[4:0])
      PVCR_ADDR_DIGITAL_POWER_CONTROL: readValue = state_reg.digitalPowerControl;
      PVCR_ADDR_ANALOG_FRONTEND_CONTROL: readValue = state_reg.analogFrontendControl;
      PVCR_ADDR_SYMBOL_ERROR_FRAME_COUNT: readValue = errorCount; // [R12]
      PVCR_ADDR_STRAP_OVERRIDE_CONTROL: readValue = state_reg.strapOverrideControl;
      default: readValue = 16'h0000;
    endcase
  end

  assign wakeEnable = state_reg.strapOverrideControl[PVCR_BIT_WAKE_ENABLE];
  // select bit 1 picks polarity, bit 0 picks the pin
  assign wakeLevel = wakeEvent ^ wakeOutputSelect[1];

  always_comb begin
    state_next = state_reg;
    state_next.mdcPrev = mdc;

    // strap is caught on the first clock after reset release
    if (!state_reg.strapDone) begin
      state_next.strapDone = 1'b1;
      state_next.strapOverrideControl[PVCR_BIT_WAKE_ENABLE] = wakeOutputEnableStrap; // [R6]
    end

    if (mdcRise) begin
      unique case (state_reg.st)
        PVCR_HUNT: begin
          if (mdioIn) begin
            if (state_reg.ones != PVCR_PREAMBLE_MIN) begin
              state_next.ones = state_reg.ones + 6'h01;
            end
          end else begin
            // a zero only counts as start after a full preamble
            state_next.st = (state_reg.ones == PVCR_PREAMBLE_MIN) ? PVCR_START : PVCR_HUNT;
            state_next.ones = 6'h00;
          end
        end
        PVCR_START: begin
          state_next.st = mdioIn ? PVCR_HEADER : PVCR_HUNT;
          state_next.bitCnt = 5'h00;
        end
        PVCR_HEADER: begin
          state_next.shift = {state_reg.shift[14:0], mdioIn};
          state_next.bitCnt = state_reg.bitCnt + 5'h01;
          if (state_reg.bitCnt == PVCR_HEADER_BITS - 5'h01) begin
            state_next.st = PVCR_TURN1;
          end
        end
        PVCR_TURN1: begin
          state_next.regAddr = state_reg.shift[4:0];
          if (!addrMatch) begin
            state_next.st = PVCR_HUNT;
          end else if (state_reg.shift[11:10] == PVCR_OP_READ) begin
            state_next.st = PVCR_TURN2;
            state_next.mdioOe = 1'b1;
            state_next.mdioOut = 1'b0;
          end else if (state_reg.shift[11:10] == PVCR_OP_WRITE) begin
            state_next.st = PVCR_TURN2;
          end else begin
            state_next.st = PVCR_HUNT;
          end
        end
        PVCR_TURN2: begin
          state_next.bitCnt = 5'h00;
          if (state_reg.mdioOe) begin
            // snapshot and clear in one edge: old count goes out [R12]
            state_next.st = PVCR_RDATA;
            state_next.shift = {readValue[14:0], 1'b0};
            state_next.mdioOut = readValue[15];
          end else begin
            state_next.st = PVCR_WDATA;
          end
        end
        PVCR_RDATA: begin
          state_next.bitCnt = state_reg.bitCnt + 5'h01;
          state_next.mdioOut = state_reg.shift[15];
          state_next.shift = {state_reg.shift[14:0], 1'b0};
          if (state_reg.bitCnt == PVCR_DATA_BITS - 5'h01) begin
            state_next.st = PVCR_HUNT;
            state_next.mdioOe = 1'b0;
            state_next.mdioOut = 1'b0;
          end
        end
        PVCR_WDATA: begin
          state_next.bitCnt = state_reg.bitCnt + 5'h01;
          state_next.shift = {state_reg.shift[14:0], mdioIn};
          if (state_reg.bitCnt == PVCR_DATA_BITS - 5'h01) begin
            state_next.st = PVCR_HUNT;
            unique case (state_reg.regAddr)
              PVCR_ADDR_DIGITAL_POWER_CONTROL:
                state_next.digitalPowerControl = {state_reg.shift[14:0], mdioIn};
              PVCR_ADDR_ANALOG_FRONTEND_CONTROL:
                state_next.analogFrontendControl = {state_reg.shift[14:0], mdioIn};
              PVCR_ADDR_STRAP_OVERRIDE_CONTROL:
                state_next.strapOverrideControl =
                  {state_reg.shift[14:0], mdioIn} & PVCR_MASK_STRAP_OVERRIDE; // [R6]
              default: ;
            endcase
          end
        end
        default: state_next.st = PVCR_HUNT;
      endcase
    end

    // pll only stops when the expanded-control mode is on and idle [R10]
    state_next.pllShutdown = state_reg.digitalPowerControl[PVCR_BIT_PLL_OFF] &&
      edpdEnable && edpdActive; // [R1]
    state_next.slowOscSelect = state_reg.analogFrontendControl[PVCR_BIT_SLOW_OSC]; // [R2]
    state_next.analogPowerDown = softPowerDown ||
      state_reg.analogFrontendControl[PVCR_BIT_SLOW_OSC]; // [R3]
    state_next.wakePinA = wakeEnable && !wakeOutputSelect[0] && wakeLevel; // [R5]
    state_next.wakePinB = wakeEnable && wakeOutputSelect[0] && wakeLevel; // [R5]
    // repeater override only counts with mii override also set [R9]
    state_next.repeaterPairingMode = repeaterStrap ||
      (state_reg.strapOverrideControl[PVCR_BIT_REPEATER] &&
       state_reg.strapOverrideControl[PVCR_BIT_MII_OVERRIDE]); // [R8]
    state_next.miiMode = miiStrap ||
      state_reg.strapOverrideControl[PVCR_BIT_MII_OVERRIDE]; // [R11]
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
      state_reg.st <= PVCR_HUNT;
      state_reg.digitalPowerControl <= PVCR_RST_DIGITAL_POWER_CONTROL;
      state_reg.analogFrontendControl <= PVCR_RST_ANALOG_FRONTEND_CONTROL;
      state_reg.strapOverrideControl <= PVCR_RST_STRAP_OVERRIDE_CONTROL; // [R11]
    end else begin
      state_reg <= state_next;
    end
  end

  assign mdioOut = state_reg.mdioOut;
  assign mdioOe = state_reg.mdioOe;
  assign pllShutdown = state_reg.pllShutdown;
  assign slowOscSelect = state_reg.slowOscSelect;
  assign analogPowerDown = state_reg.analogPowerDown;
  assign wakePinA = state_reg.wakePinA;
  assign wakePinB = state_reg.wakePinB;
  assign repeaterPairingMode = state_reg.repeaterPairingMode;
  assign miiMode = state_reg.miiMode;

endmodule // pvcr_registers

// ==== dv/pvcr_assertions.sv ====
// pvcr_checker: port-level properties of the vendor control registers.
// assumes it is bound into pvcr_registers and sees only its ports.
`timescale 1ns/10ps
module pvcr_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic mdioOut,
  input wire logic mdioOe,
  input wire logic edpdEnable,
  input wire logic edpdActive,
  input wire logic softPowerDown,
  input wire logic [1:0] wakeOutputSelect,
  input wire logic wakeEvent,
  input wire logic repeaterStrap,
  input wire logic miiStrap,
  input wire logic pllShutdown,
  input wire logic slowOscSelect,
  input wire logic analogPowerDown,
  input wire logic wakePinA,
  input wire logic wakePinB,
  input wire logic repeaterPairingMode,
  input wire logic miiMode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_pll_needs_energy_detect_power_down: assert property (
    pllShutdown |-> $past(edpdEnable && edpdActive)) else $error("pll off outside power-down");
  a_osc_powers_afe: assert property (
    slowOscSelect |-> analogPowerDown) else $error("slow osc without analog power-down");
  a_soft_pd_pass: assert property (
    $past(reset_n) && $past(softPowerDown) |-> analogPowerDown) else $error("power-down lost");
  a_mii_strap_wins: assert property (
    $past(reset_n) && $past(miiStrap) |-> miiMode) else $error("mii strap ignored");
  a_rep_strap_wins: assert property (
    $past(reset_n) && $past(repeaterStrap) |-> repeaterPairingMode) else $error("strap ignored");
  a_rep_needs_mii: assert property (
    repeaterPairingMode && !$past(repeaterStrap) |-> miiMode) else $error("repeater without mii");
  a_wake_one_pin: assert property (
    !(wakePinA && wakePinB)) else $error("both wake pins active");
  a_wake_polarity: assert property (
    wakePinA || wakePinB |-> $past(wakeEvent ^ wakeOutputSelect[1])) else $error("wake polarity");
  a_wake_pin_sel: assert property (
    wakePinB |-> $past(wakeOutputSelect[0])) else $error("wake pin select");
  a_turn_low: assert property (
    $rose(mdioOe) |-> !mdioOut [*4]) else $error("turnaround not low");
  c_read: cover property ($rose(mdioOe));
  c_pll: cover property (pllShutdown);
  c_rep: cover property (repeaterPairingMode && !repeaterStrap);
endmodule // pvcr_checker
bind pvcr_registers pvcr_checker i_pvcr_checker (.clk, .reset_n, .mdioOut, .mdioOe,
  .edpdEnable, .edpdActive, .softPowerDown, .wakeOutputSelect, .wakeEvent, .repeaterStrap,
  .miiStrap, .pllShutdown, .slowOscSelect, .analogPowerDown, .wakePinA, .wakePinB,
  .repeaterPairingMode, .miiMode);

// ==== dv/pvcr_smi_master.sv ====
// pvcr_smi_master: management controller model issuing mdc/mdio frames.
// assumes a pull-up on mdio; mdc rests low between frames.
`timescale 1ns/10ps
module pvcr_smi_master (
  input wire logic clk,
  input wire logic mdioOut,
  input wire logic mdioOe,
  output logic mdc,
  output logic mdioIn
);
  logic drv = 1'b1;
  logic drvEn = 1'b0;
  // released line floats to the pull-up level
  assign mdioIn = drvEn ? drv : (mdioOe ? mdioOut : 1'b1);
  initial mdc = 1'b0;
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
      input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hffffffff, 2'h1, op, pa, ra, 2'h2, wd};
    rd = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      mdc <= 1'b0;
      drvEn <= (i < 46) || (op == 2'h1);
      drv <= bits[63-i];
      repeat (3) @(posedge clk);
      // data put after the previous rise is sampled at this rise
      if (i >= 48) rd[63-i] = mdioIn;
      mdc <= 1'b1;
      repeat (3) @(posedge clk);
    end
    @(posedge clk);
    mdc <= 1'b0;
    drvEn <= 1'b0;
  endtask
endmodule // pvcr_smi_master

// ==== dv/pvcr_registers_tb_top.sv ====
// pvcr_registers_tb_top: self-checking bench for the vendor control registers.
// assumes pvcr_smi_master as controller and pvcr_checker bound to the design.
`timescale 1ns/10ps
module pvcr_registers_tb_top;
  import pvcr_pkg::*;
  localparam logic [4:0] rPwr = PVCR_ADDR_DIGITAL_POWER_CONTROL;
  localparam logic [4:0] rAfe = PVCR_ADDR_ANALOG_FRONTEND_CONTROL;
  localparam logic [4:0] rCnt = PVCR_ADDR_SYMBOL_ERROR_FRAME_COUNT;
  localparam logic [4:0] rOvr = PVCR_ADDR_STRAP_OVERRIDE_CONTROL;
  logic clk = 1'b0, reset_n = 1'b0, mdc, mdioIn, mdioOut, mdioOe, pllShutdown, slowOscSelect;
  logic analogPowerDown, wakePinA, wakePinB, repeaterPairingMode, miiMode;
  logic [4:0] phyAddress;
  logic wakeOutputEnableStrap, repeaterStrap = 0, miiStrap = 0, edpdEnable = 0, edpdActive = 0;
  logic softPowerDown = 0, wakeEvent = 0, symbolErrorFrame = 0;
  logic [1:0] wakeOutputSelect = 2'h0;
  logic [31:0] seed, r;
  int errCount = 0, checkCount = 0;
  always #10 clk = ~clk;
  pvcr_registers i_pvcr_registers (.clk, .reset_n, .mdc, .mdioIn, .mdioOut, .mdioOe, .phyAddress,
    .wakeOutputEnableStrap, .repeaterStrap, .miiStrap, .edpdEnable, .edpdActive, .softPowerDown,
    .wakeOutputSelect, .wakeEvent, .symbolErrorFrame, .pllShutdown, .slowOscSelect,
    .analogPowerDown, .wakePinA, .wakePinB, .repeaterPairingMode, .miiMode);
  pvcr_smi_master i_pvcr_smi_master (.clk, .mdioOut, .mdioOe, .mdc, .mdioIn);
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    chk_reg({15'h0000, got}, {15'h0000, exp});
  endtask
  function automatic logic [1:0] wake_exp(logic en, logic [1:0] sel, logic ev);
    return {en & sel[0] & (ev ^ sel[1]), en & !sel[0] & (ev ^ sel[1])};
  endfunction
  task automatic rd(input logic [4:0] pa, input logic [4:0] ra, output logic [15:0] d);
    i_pvcr_smi_master.frame(PVCR_OP_READ, pa, ra, 16'h0000, d);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] unused;
    i_pvcr_smi_master.frame(PVCR_OP_WRITE, phyAddress, ra, d, unused);
    repeat (4) @(posedge clk);
  endtask
  task automatic rchk(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] d;
    rd(pa, ra, d);
    chk_reg(d, exp);
  endtask
  task automatic printVerdict();
    if (errCount == 0 && checkCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    errCount++;
    printVerdict();
  end
  initial begin
    logic [15:0] d, d2;
    logic [1:0] e;
    int n;
    seed = 32'haec309e6;
    r = $random(seed);
    phyAddress <= {r[4:1], 1'b1};
    wakeOutputEnableStrap <= r[8];
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rchk(phyAddress, rPwr, 16'h0000);
    rchk(phyAddress, rAfe, 16'h0000);
    rchk(phyAddress, rCnt, 16'h0000);
    rchk(phyAddress, rOvr, {wakeOutputEnableStrap, 15'h0001});
    rchk(phyAddress, 5'h12, 16'h0000);
    r = $random(seed);
    wr(rPwr, r[15:0]);
    rchk(phyAddress, rPwr, r[15:0]);
    wr(rAfe, r[31:16]);
    rchk(phyAddress, rAfe, r[31:16]);
    wr(rOvr, ~r[15:0]);
    rchk(phyAddress, rOvr, ~r[15:0] & PVCR_MASK_STRAP_OVERRIDE);
    wr(rCnt, r[15:0]);
    rchk(phyAddress, rCnt, 16'h0000);
    wr(rPwr, 16'h0010);
    for (int k = 0; k < 4; k++) begin
      edpdEnable <= k[0];
      edpdActive <= k[1];
      repeat (3) @(posedge clk);
      chk_pin(pllShutdown, k == 3);
    end
    wr(rPwr, 16'h0000);
    chk_pin(pllShutdown, 1'b0);
    wr(rAfe, 16'h0020);
    chk_pin(slowOscSelect, 1'b1);
    chk_pin(analogPowerDown, 1'b1);
    wr(rAfe, 16'h0000);
    chk_pin(analogPowerDown, 1'b0);
    // repeater without the mii bit must stay off
    wr(rOvr, 16'h0080);
    chk_pin(repeaterPairingMode, 1'b0);
    chk_pin(miiMode, 1'b0);
    miiStrap <= 1'b1;
    repeaterStrap <= 1'b1;
    repeat (3) @(posedge clk);
    chk_pin(miiMode, 1'b1);
    chk_pin(repeaterPairingMode, 1'b1);
    miiStrap <= 1'b0;
    repeaterStrap <= 1'b0;
    wr(rOvr, 16'h0081);
    chk_pin(repeaterPairingMode, 1'b1);
    chk_pin(miiMode, 1'b1);
    wr(rOvr, 16'h8001);
    for (int k = 0; k < 8; k++) begin
      wakeOutputSelect <= k[1:0];
      wakeEvent <= k[2];
      repeat (3) @(posedge clk);
      e = wake_exp(1'b1, k[1:0], k[2]);
      chk_pin(wakePinA, e[0]);
      chk_pin(wakePinB, e[1]);
    end
    rchk(5'h00, rOvr, 16'h8001);
    wr(rOvr, 16'h0201);
    rchk(5'h00, rOvr, 16'hffff);
    // wake bit now clear: an active level with select 0 must not reach pin A
    wakeEvent <= 1'b1;
    wakeOutputSelect <= 2'h0;
    repeat (3) @(posedge clk);
    chk_pin(wakePinA, 1'b0);
    n = 0;
    repeat (20) begin
      r = $random(seed);
      symbolErrorFrame <= r[0];
      softPowerDown <= r[1];
      n += r[0];
      @(posedge clk);
      symbolErrorFrame <= 1'b0;
      @(posedge clk);
    end
    rchk(phyAddress, rCnt, n[15:0]);
    fork
      rd(phyAddress, rCnt, d);
      repeat (12) begin
        repeat (37) @(posedge clk);
        symbolErrorFrame <= 1'b1;
        @(posedge clk);
        symbolErrorFrame <= 1'b0;
      end
      // one frame lands on the snapshot edge (mdc rise 47 of the read)
      begin
        repeat (333) @(posedge clk);
        symbolErrorFrame <= 1'b1;
        @(posedge clk);
        symbolErrorFrame <= 1'b0;
      end
    join
    rd(phyAddress, rCnt, d2);
    chk_reg(d + d2, 16'h000d);
    printVerdict();
  end
endmodule // pvcr_registers_tb_top
